// file: dcca_channel.sv
// One capture/compare channel: register, edge capture, compare modes.
// Assumes the pin input is synchronous-sampled here; pin drive is local.
`default_nettype none
`timescale 1ns/1ps
module dcca_channel
  import dcca_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Configuration
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_tsel,
  input  wire logic        i_dbl,
  input  wire logic        i_out_cap,
  // Timers
  input  wire logic [15:0] i_tmr_a,
  input  wire logic [15:0] i_tmr_b,
  input  wire logic        i_tick_a,
  input  wire logic        i_tick_b,
  input  wire logic        i_ovf_a,
  input  wire logic        i_ovf_b,
  // Pin and partner
  input  wire logic        i_pin,
  input  wire logic        i_toggle_in,
  // Software access
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  // Results
  output logic      [15:0] o_value_ff,
  output logic             o_event,
  output logic             o_toggle_out,
  output logic             o_pin_ff
);
  logic        sync1_ff;
  logic        sync2_ff;
  logic        last_ff;
  logic        armed_ff;
  logic [15:0] tmr;
  logic        tick;
  logic        ovf;
  logic        rise;
  logic        fall;
  logic        cap_hit;
  logic        match;
  logic        once_hit;
  logic        m3;

  assign tmr  = i_tsel ? i_tmr_b : i_tmr_a;
  assign tick = i_tsel ? i_tick_b : i_tick_a;
  assign ovf  = i_tsel ? i_ovf_b : i_ovf_a;
  assign rise = sync2_ff & ~last_ff;
  assign fall = ~sync2_ff & last_ff;
  assign m3   = (i_mode == CMP_M3);

  // Two-flop synchroniser, edge taken after the second stage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else begin
      sync1_ff <= i_pin;
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
    end
  end

  always_comb begin
    case (dcca_mode_t'(i_mode))
      CAP_RISE: cap_hit = rise;
      CAP_FALL: cap_hit = fall;
      CAP_BOTH: cap_hit = rise | fall;
      default:  cap_hit = 1'b0;
    endcase
  end

  // Compared once per timer step, so a stopped timer does not retrigger
  assign match    = i_mode[2] & tick & (tmr == o_value_ff);
  // The overflow cycle rearms at once, so a match at the reload value counts
  assign once_hit = match & (armed_ff | ovf) & i_mode[1];
  assign o_event  = cap_hit | (match & ~i_mode[1]) | once_hit;
  assign o_toggle_out = match & i_dbl & (i_mode == CMP_M1);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      armed_ff <= 1'b1;
    end else if (once_hit) begin
      armed_ff <= 1'b0;
    end else if (ovf) begin
      armed_ff <= 1'b1;
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_value_ff <= TMR_RST;
    end else if (cap_hit) begin
      o_value_ff <= tmr;
    end else if (i_wr) begin
      o_value_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_out_cap) begin
      o_pin_ff <= 1'b0;
    end else if (m3 && once_hit) begin
      o_pin_ff <= 1'b1;
    end else if (m3 && ovf) begin
      o_pin_ff <= 1'b0;
    end else if ((match && i_mode == CMP_M1 && !i_dbl) || i_toggle_in) begin
      o_pin_ff <= ~o_pin_ff;
    end
  end

  a_capture_value: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    cap_hit |=> o_value_ff == $past(tmr))
    else $error("capture lost timer value");
  a_mode3_set: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_out_cap && m3 && once_hit |=> o_pin_ff)
    else $error("mode 3 match did not set pin");
  a_mode0_hold: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_mode == CMP_M0 && $stable(i_mode) && !i_toggle_in |=> $stable(o_pin_ff))
    else $error("mode 0 disturbed the pin");
  a_once_disarm: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    once_hit |=> !armed_ff)
    else $error("single event not disarmed");
endmodule
`default_nettype wire

// file: dcca_pins_model.sv
// Far-side model: channel pin levels, shared count line, overflow strobe.
// Assumes the bench calls its tasks; lines change only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dcca_pins_model (
  // Clock
  input  wire logic        i_clk,
  // Lines toward the array
  output logic      [31:0] o_ch_pin,
  output logic             o_cnt_pin,
  output logic             o_gp_ovf
);
  initial begin
    o_ch_pin  = 32'h0;
    o_cnt_pin = 1'b0;
    o_gp_ovf  = 1'b0;
  end
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge i_clk);
    o_ch_pin[idx] <= lvl;
  endtask
  // Gap sets a prompt or a slow pace; strobe is one cycle wide
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      @(posedge i_clk);
      o_cnt_pin <= 1'b1;
      o_gp_ovf  <= 1'b1;
      @(posedge i_clk);
      o_gp_ovf  <= 1'b0;
      repeat (2) @(posedge i_clk);
      o_cnt_pin <= 1'b0;
      repeat (2 + gap) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: dcca_pkg.sv
// Constants, field layout and encodings of the capture/compare array.
// Assumes a single system clock; no tool-specific features.
`default_nettype none
package dcca_pkg;
  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_UNITS   = 2;
  localparam int CH_PER_UNIT = 16;
  localparam int NUM_CH      = 32;
  localparam int TMR_PER_U   = 2;
  localparam int NUM_TMR     = 4;
  localparam int TMR_W       = 16;
  localparam int OUT_CH_U2   = 12;
  localparam int DBL_SPAN    = 8;
  localparam int ADDR_W      = 8;
  // ----------------------------------------------------------------
  // Word offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] UNIT_STRIDE  = 8'h40;
  localparam logic [7:0] OFS_CH_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CH_VAL   = 8'h10;
  localparam logic [7:0] OFS_CH_IRQ   = 8'h20;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h30;
  localparam logic [7:0] OFS_TMR_VAL  = 8'h32;
  localparam logic [7:0] OFS_TMR_REL  = 8'h34;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CH_TSEL_BIT  = 3;
  localparam int CH_DBL_BIT   = 4;
  localparam int TMR_SRC_LSB  = 3;
  localparam int TMR_RUN_BIT  = 5;
  localparam int IRQ_IE_BIT   = 6;
  localparam int IRQ_IR_BIT   = 7;
  localparam logic [4:0]  CH_CTRL_RST  = 5'h00;
  localparam logic [5:0]  TMR_CTRL_RST = 6'h00;
  localparam logic [7:0]  IRQ_RST      = 8'h00;
  localparam logic [15:0] TMR_RST      = 16'h0000;
  localparam logic [15:0] TMR_MAX      = 16'hFFFF;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DOC_CLK_MHZ = 40;
  localparam int MIN_RES_NS  = 200;
  localparam int MIN_DIV     = MIN_RES_NS * DOC_CLK_MHZ / 1000;
  localparam int PRESC_W     = 10;
  localparam logic [9:0] PRESC_MAX = 10'h3FF;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000, CAP_RISE = 3'b001, CAP_FALL = 3'b010,
    CAP_BOTH = 3'b011, CMP_M0 = 3'b100, CMP_M1 = 3'b101,
    CMP_M2 = 3'b110, CMP_M3 = 3'b111
  } dcca_mode_t;
  typedef enum logic [1:0] {
    SRC_PRESC = 2'b00, SRC_GPT = 2'b01, SRC_EXT = 2'b10
  } dcca_src_t;
endpackage
`default_nettype wire

// file: dcca_timer.sv
// One reloadable 16-bit unit timer with clock source select.
// Assumes the shared prescaler counter runs free in the top.
`default_nettype none
`timescale 1ns/1ps
module dcca_timer
  import dcca_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Configuration
  input  wire logic        i_run,
  input  wire logic [1:0]  i_src,
  input  wire logic [2:0]  i_sel,
  input  wire logic        i_ext_ok,
  // Count sources
  input  wire logic [9:0]  i_presc_cnt,
  input  wire logic        i_gp_ovf,
  input  wire logic        i_ext_evt,
  // Software access
  input  wire logic        i_wr_val,
  input  wire logic        i_wr_rel,
  input  wire logic [15:0] i_wdata,
  // State
  output logic      [15:0] o_value_ff,
  output logic      [15:0] o_reload_ff,
  output logic             o_tick_ff,
  output logic             o_ovf_ff
);
  logic [9:0] mask;
  logic       presc_tick;
  logic       tick;
  logic       step;
  logic       wrap;

  // Divide by 8 at code 0 up to 1024 at code 7
  assign mask       = PRESC_MAX >> (3'd7 - i_sel);
  assign presc_tick = &(i_presc_cnt | ~mask);
  assign step       = i_run & tick;
  assign wrap       = (o_value_ff == TMR_MAX);

  always_comb begin
    case (dcca_src_t'(i_src))
      SRC_PRESC: tick = presc_tick;
      SRC_GPT:   tick = i_gp_ovf;
      SRC_EXT:   tick = i_ext_ok & i_ext_evt;
      default:   tick = 1'b0;
    endcase
  end

  // Software write wins over a count in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_value_ff <= TMR_RST;
    end else if (i_wr_val) begin
      o_value_ff <= i_wdata;
    end else if (step) begin
      o_value_ff <= wrap ? o_reload_ff : o_value_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reload_ff <= TMR_RST;
    end else if (i_wr_rel) begin
      o_reload_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_tick_ff <= 1'b0;
      o_ovf_ff  <= 1'b0;
    end else begin
      o_tick_ff <= step & ~i_wr_val;
      o_ovf_ff  <= step & ~i_wr_val & wrap;
    end
  end

  a_timer_reload: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    step && wrap && !i_wr_val |=> o_ovf_ff && o_value_ff == $past(o_reload_ff))
    else $error("timer did not reload on overflow");
  a_presc_rate: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    step && i_src == SRC_PRESC && i_sel == 3'd0 |-> i_presc_cnt[2:0] == 3'h7)
    else $error("prescaler tick off its period");
endmodule
`default_nettype wire

// file: dcca_top.sv
// Dual capture/compare array: 2 units x 16 channels, 4 timers, bus slave.
// Assumes an Avalon-MM master with word addresses; pins sampled on i_clk.
//
// Operation
// - Two independent units of 16 channels, 32 channels total.
// - Each unit has two 16-bit timers with reload registers.
// - Timer clock from prescaled system clock or general timer overflow.
// - First timer of each unit may also count external pin events.
// - Each channel selects its unit timer and capture or compare.
// - Each channel owns one pin: capture input or compare output.
// - Second unit drives only 12 outputs; top four pins input only.
// - Same signal on both count pins keeps both first timers in step.
// - Capture copies assigned timer into register and requests interrupt.
// - Capture edge selectable as rising, falling or either.
// - Compare channels compare on each timer step and act on equality.
// - Mode 0: interrupt only, pin unchanged, many per period.
// - Mode 1: pin toggles on every match, many per period.
// - Mode 2: interrupt only, at most one per timer period.
// - Mode 3: match sets pin, timer overflow clears, once per period.
// - Double mode: two registers toggle one shared pin on matches.
// - Three-bit select gives prescaler 8 through 1024.
// - Smallest prescaler gives eight-clock timer resolution.
// - One period runs from reload value up to overflow.
// - Interrupt control low byte: flag, enable, priority, group; upper zero.
`default_nettype none
`timescale 1ns/1ps
module dcca_top
  import dcca_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Avalon-MM slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Channel pins
  input  wire logic [31:0] i_ch_pin,
  output logic      [31:0] o_ch_pin,
  output logic      [31:0] o_ch_pin_oe,
  // Count sources
  input  wire logic        i_unit1_cnt_pin,
  input  wire logic        i_unit2_cnt_pin,
  input  wire logic        i_gp_ovf,
  // Interrupt requests per channel
  output logic      [31:0] o_ch_irq
);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic        ack_ff;
  logic        req;
  logic        take_wr;
  logic [15:0] wdata;
  logic [31:0] rdata;
  logic [31:0] readdata_ff;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_ff;
  assign take_wr           = i_avs_write & ack_ff;
  assign o_avs_readdata    = readdata_ff;

  // Disabled byte lanes keep the low bits of the data at zero
  assign wdata = {i_avs_byteenable[1] ? i_avs_writedata[15:8] : 8'h00,
                  i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00};

  // One wait state: decode in the first cycle, complete in the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (i_avs_read && !ack_ff) begin
      readdata_ff <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and count pins
  // ----------------------------------------------------------------
  logic [9:0] presc_ff;
  logic [1:0] cnt_s1_ff;
  logic [1:0] cnt_s2_ff;
  logic [1:0] cnt_last_ff;
  logic [1:0] ext_evt;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      presc_ff <= 10'h000;
    end else begin
      presc_ff <= presc_ff + 10'h001;
    end
  end

  // Identical pipelines for both units keep shared inputs in step
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_s1_ff   <= 2'h0;
      cnt_s2_ff   <= 2'h0;
      cnt_last_ff <= 2'h0;
    end else begin
      cnt_s1_ff   <= {i_unit2_cnt_pin, i_unit1_cnt_pin};
      cnt_s2_ff   <= cnt_s1_ff;
      cnt_last_ff <= cnt_s2_ff;
    end
  end
  assign ext_evt = cnt_s2_ff & ~cnt_last_ff;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  logic [5:0]  tmr_ctrl_ff [NUM_TMR];
  logic [15:0] tmr_val     [NUM_TMR];
  logic [15:0] tmr_rel     [NUM_TMR];
  logic [3:0]  tmr_tick;
  logic [3:0]  tmr_ovf;

  for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
    localparam logic [7:0] BASE = UNIT_STRIDE * 8'(t / TMR_PER_U) + 8'(t % TMR_PER_U);
    logic wr_ctrl;
    logic wr_val;
    logic wr_rel;
    assign wr_ctrl = take_wr && i_avs_address == BASE + OFS_TMR_CTRL;
    assign wr_val  = take_wr && i_avs_address == BASE + OFS_TMR_VAL;
    assign wr_rel  = take_wr && i_avs_address == BASE + OFS_TMR_REL;

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        tmr_ctrl_ff[t] <= TMR_CTRL_RST;
      end else if (wr_ctrl) begin
        tmr_ctrl_ff[t] <= wdata[5:0];
      end
    end

    dcca_timer u_timer (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_run       (tmr_ctrl_ff[t][TMR_RUN_BIT]),
      .i_src       (tmr_ctrl_ff[t][TMR_SRC_LSB+:2]),
      .i_sel       (tmr_ctrl_ff[t][2:0]),
      .i_ext_ok    ((t % TMR_PER_U) == 0),
      .i_presc_cnt (presc_ff),
      .i_gp_ovf    (i_gp_ovf),
      .i_ext_evt   (ext_evt[t / TMR_PER_U]),
      .i_wr_val    (wr_val),
      .i_wr_rel    (wr_rel),
      .i_wdata     (wdata),
      .o_value_ff  (tmr_val[t]),
      .o_reload_ff (tmr_rel[t]),
      .o_tick_ff   (tmr_tick[t]),
      .o_ovf_ff    (tmr_ovf[t])
    );
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  logic [4:0]  ch_ctrl_ff [NUM_CH];
  logic [7:0]  irq_ff     [NUM_CH];
  logic [15:0] ch_val     [NUM_CH];
  logic [31:0] ch_evt;
  logic [31:0] tog_out;
  logic [31:0] out_cap;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    localparam int U = g / CH_PER_UNIT;
    localparam int I = g % CH_PER_UNIT;
    localparam logic [7:0] BASE = UNIT_STRIDE * 8'(U) + 8'(I);
    logic wr_ctrl;
    logic wr_val;
    logic wr_irq;
    logic tog_in;
    assign wr_ctrl = take_wr && i_avs_address == BASE + OFS_CH_CTRL;
    assign wr_val  = take_wr && i_avs_address == BASE + OFS_CH_VAL;
    assign wr_irq  = take_wr && i_avs_address == BASE + OFS_CH_IRQ;
    // Channel n+8 in double mode toggles the pin of channel n
    assign tog_in  = (I < DBL_SPAN) ? tog_out[(g + DBL_SPAN) % NUM_CH] : 1'b0;
    assign out_cap[g] = (U == 0) || (I < OUT_CH_U2);

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        ch_ctrl_ff[g] <= CH_CTRL_RST;
      end else if (wr_ctrl) begin
        ch_ctrl_ff[g] <= wdata[4:0];
      end
    end

    // A hardware request in the clearing cycle is kept
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        irq_ff[g] <= IRQ_RST;
      end else begin
        irq_ff[g][6:0] <= wr_irq ? wdata[6:0] : irq_ff[g][6:0];
        irq_ff[g][IRQ_IR_BIT] <= ch_evt[g] | (wr_irq ? wdata[IRQ_IR_BIT]
                                                     : irq_ff[g][IRQ_IR_BIT]);
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        o_ch_irq[g] <= 1'b0;
      end else begin
        o_ch_irq[g] <= irq_ff[g][IRQ_IR_BIT] & irq_ff[g][IRQ_IE_BIT];
      end
    end

    assign o_ch_pin_oe[g] = out_cap[g] & ch_ctrl_ff[g][2] & ~ch_ctrl_ff[g][CH_DBL_BIT];

    dcca_channel u_ch (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_mode       (ch_ctrl_ff[g][2:0]),
      .i_tsel       (ch_ctrl_ff[g][CH_TSEL_BIT]),
      .i_dbl        (ch_ctrl_ff[g][CH_DBL_BIT] && I >= DBL_SPAN),
      .i_out_cap    (out_cap[g]),
      .i_tmr_a      (tmr_val[U * TMR_PER_U]),
      .i_tmr_b      (tmr_val[U * TMR_PER_U + 1]),
      .i_tick_a     (tmr_tick[U * TMR_PER_U]),
      .i_tick_b     (tmr_tick[U * TMR_PER_U + 1]),
      .i_ovf_a      (tmr_ovf[U * TMR_PER_U]),
      .i_ovf_b      (tmr_ovf[U * TMR_PER_U + 1]),
      .i_pin        (i_ch_pin[g]),
      .i_toggle_in  (tog_in),
      .i_wr         (wr_val),
      .i_wdata      (wdata),
      .o_value_ff   (ch_val[g]),
      .o_event      (ch_evt[g]),
      .o_toggle_out (tog_out[g]),
      .o_pin_ff     (o_ch_pin[g])
    );
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped words read zero; upper byte of interrupt control is zero
  always_comb begin
    rdata = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (i_avs_address == UNIT_STRIDE * 8'(c / CH_PER_UNIT) + 8'(c % CH_PER_UNIT)
          + OFS_CH_CTRL) begin
        rdata = {27'h0, ch_ctrl_ff[c]};
      end
      if (i_avs_address == UNIT_STRIDE * 8'(c / CH_PER_UNIT) + 8'(c % CH_PER_UNIT)
          + OFS_CH_VAL) begin
        rdata = {16'h0, ch_val[c]};
      end
      if (i_avs_address == UNIT_STRIDE * 8'(c / CH_PER_UNIT) + 8'(c % CH_PER_UNIT)
          + OFS_CH_IRQ) begin
        rdata = {24'h0, irq_ff[c]};
      end
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      if (i_avs_address == UNIT_STRIDE * 8'(t / TMR_PER_U) + 8'(t % TMR_PER_U)
          + OFS_TMR_CTRL) begin
        rdata = {26'h0, tmr_ctrl_ff[t]};
      end
      if (i_avs_address == UNIT_STRIDE * 8'(t / TMR_PER_U) + 8'(t % TMR_PER_U)
          + OFS_TMR_VAL) begin
        rdata = {16'h0, tmr_val[t]};
      end
      if (i_avs_address == UNIT_STRIDE * 8'(t / TMR_PER_U) + 8'(t % TMR_PER_U)
          + OFS_TMR_REL) begin
        rdata = {16'h0, tmr_rel[t]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_bus_one_wait: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    req && !ack_ff |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest))
    else $error("bus wait state count wrong");
  a_irq_set_wins: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ch_evt[0] |=> irq_ff[0][IRQ_IR_BIT])
    else $error("interrupt request lost");
  a_input_only: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_ch_pin_oe[31:28] == 4'h0 && o_ch_pin[31:28] == 4'h0)
    else $error("input-only pin driven");
  a_ext_lockstep: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    $past(i_unit1_cnt_pin == i_unit2_cnt_pin, 2) && $past(i_unit1_cnt_pin == i_unit2_cnt_pin, 3)
    |-> ext_evt[0] == ext_evt[1])
    else $error("count pins out of step");
endmodule
`default_nettype wire

// file: dcca_top_tb_top.sv
// Self-checking bench for the dual capture/compare array.
// Assumes dcca_pkg and dcca_pins_model; registers reached over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module dcca_top_tb_top
  import dcca_pkg::*;
;
  logic        i_clk;
  logic        i_sys_rst;
  logic [7:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        wait_rq;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic        cnt;
  logic        gp;
  logic [31:0] irq;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  logic [15:0] r;
  int          n;
  int          errors;
  int          n_tests;

  dcca_top u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq),
    .i_ch_pin(pin_in), .o_ch_pin(pin_out), .o_ch_pin_oe(pin_oe),
    .i_unit1_cnt_pin(cnt), .i_unit2_cnt_pin(cnt),
    .i_gp_ovf(gp), .o_ch_irq(irq)
  );
  dcca_pins_model u_pins (.i_clk(i_clk), .o_ch_pin(pin_in), .o_cnt_pin(cnt), .o_gp_ovf(gp));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge i_clk);
      k++;
    end while (wait_rq !== 1'b0 && k < 50);
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      errors++;
      end_sim();
    end
  endtask

  // Cycles from a rise of one pin to its next fall
  task automatic high_time(input int b, input int exp, input string what);
    int k;
    k = 0;
    while (pin_out[b] !== 1'b0 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    while (pin_out[b] !== 1'b1 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    k = 0;
    while (pin_out[b] === 1'b1 && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    check(what, k, exp);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  // Read data stand at the edge that sees waitrequest low
  always @(posedge i_clk) begin
    if (rd && wait_rq === 1'b0 && exp_q.size() > 0)
      check("readdata", rdat, {16'h0000, exp_q.pop_front()});
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {rd, wr, addr, wdat} = '0;
    errors = 0;
    n_tests = 0;
    seed = 32'h53d1;
    i_sys_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdc(8'h20, 16'h0000);
    rdc(8'h36, 16'h0000);
    seed = lfsr(seed);
    n = 32'(seed[2:0]) + 1;
    bus(1'b1, 8'h30, 16'h0030);
    bus(1'b1, 8'h70, 16'h0030);
    bus(1'b1, 8'h31, 16'h0028);
    u_pins.pulse(n, seed[3] ? 6 : 0);
    repeat (8) @(posedge i_clk);
    rdc(8'h32, 16'(n));
    rdc(8'h72, 16'(n));
    rdc(8'h33, 16'(n));
    seed = lfsr(seed);
    r = seed[15:0];
    bus(1'b1, 8'h73, r);
    bus(1'b1, 8'h41, {12'h000, 1'b1, CAP_FALL});
    u_pins.set_pin(17, 1'b1);
    repeat (6) @(posedge i_clk);
    rdc(8'h51, 16'h0000);
    u_pins.set_pin(17, 1'b0);
    repeat (6) @(posedge i_clk);
    rdc(8'h51, r);
    rdc(8'h61, 16'h0080);
    bus(1'b1, 8'h61, 16'hFFFF);
    rdc(8'h61, 16'h00FF);
    check("irq17", {31'h0, irq[17]}, 32'h1);
    bus(1'b1, 8'h42, {12'h000, 1'b1, CAP_BOTH});
    u_pins.set_pin(18, 1'b1);
    repeat (6) @(posedge i_clk);
    rdc(8'h52, r);
    bus(1'b1, 8'h52, 16'h0000);
    u_pins.set_pin(18, 1'b0);
    repeat (6) @(posedge i_clk);
    rdc(8'h52, r);
    bus(1'b1, 8'h33, 16'hFFFE);
    bus(1'b1, 8'h10, 16'h0000);
    bus(1'b1, 8'h00, {12'h000, 1'b1, CMP_M1});
    bus(1'b1, 8'h4C, {12'h000, 1'b0, CMP_M1});
    bus(1'b1, 8'h31, 16'h0020);
    check("pin0_early", {31'h0, pin_out[0]}, 32'h0);
    repeat (40) @(posedge i_clk);
    check("pin0", {31'h0, pin_out[0]}, 32'h1);
    check("oe0", {31'h0, pin_oe[0]}, 32'h1);
    check("oe28", {31'h0, pin_oe[28]}, 32'h0);
    rdc(8'h20, 16'h0080);
    // Short period FFF0..FFFF: eight ticks of eight clocks between events
    bus(1'b1, 8'h35, 16'hFFF0);
    bus(1'b1, 8'h10, 16'hFFF4);
    bus(1'b1, 8'h18, 16'hFFFC);
    bus(1'b1, 8'h08, {11'h000, 1'b1, 1'b1, CMP_M1});
    bus(1'b1, 8'h11, 16'hFFF8);
    bus(1'b1, 8'h01, {12'h000, 1'b1, CMP_M3});
    bus(1'b1, 8'h12, 16'hFFF8);
    bus(1'b1, 8'h02, {12'h000, 1'b1, CMP_M2});
    bus(1'b1, 8'h13, 16'hFFF8);
    bus(1'b1, 8'h03, {12'h000, 1'b1, CMP_M0});
    bus(1'b1, 8'h33, 16'hFFF0);
    high_time(0, 64, "pin0_double");
    high_time(1, 64, "pin1_mode3");
    check("pin3", {31'h0, pin_out[3]}, 32'h0);
    check("oe8", {31'h0, pin_oe[8]}, 32'h0);
    rdc(8'h21, 16'h0080);
    rdc(8'h22, 16'h0080);
    rdc(8'h23, 16'h0080);
    rdc(8'h28, 16'h0080);
    end_sim();
  end
endmodule
`default_nettype wire
